// File: logic/psr_bank.sv
// Read-only production signature bank with AXI4-Lite access and reset-time trim copy.
`timescale 1ns/10ps
// Function
// - Index 0x03 is copied into trim register B of the fast oscillator loop on every reset.
// - Index 0x04 is copied into trim register A of the fast oscillator loop on every reset.
// - Indices 0x08 to 0x0D read back lot number bytes 0 to 5 in rising order.
// - Index 0x10 reads back the wafer number, one part of the device serial number.
// - Indices 0x12/0x13 read die X low then high, and 0x14/0x15 read die Y low then high.
// - The USB pad trim bytes are never pushed into the USB block by hardware.
// - Index 0x1C holds a trim that, written to loop trim B, retunes the oscillator to 48MHz.
// - The converter A trims at 0x20 and 0x21 are never pushed into the converter by hardware.
module psr_bank (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire psr_pkg::psr_row_t          factory_row,
   output psr_pkg::psr_fll_trim_t          fll_trim,
   input  wire logic [psr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [psr_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [psr_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [psr_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      psr_pkg::psr_row_t          bank;
      psr_pkg::psr_fll_trim_t     trim;
      logic                       aw_got;
      logic                       w_got;
      logic [psr_pkg::ADDR_W-1:0] awaddr;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       rvalid;
      logic [1:0]                 rresp;
      logic [psr_pkg::DATA_W-1:0] rdata;
   } psr_state_t;

   psr_state_t state;
   psr_state_t next_state;

   // Maps a byte address to a storage slot; the two low address bits are ignored.
   function automatic psr_pkg::psr_decode_t psr_decode(input logic [psr_pkg::ADDR_W-1:0] addr);
      psr_pkg::psr_decode_t d;
      d = '0;
      for (int k = 0; k < psr_pkg::NUM_BYTES; k++) begin
         if (addr[psr_pkg::ADDR_W-1:2] == psr_pkg::SLOT_INDEX[k]) begin
            d.hit  = 1'b1;
            d.slot = k[psr_pkg::SLOT_W-1:0];
         end
      end
      return d;
   endfunction

   logic                 aw_take;
   logic                 w_take;
   logic                 ar_take;
   psr_pkg::psr_decode_t wr_dec;
   psr_pkg::psr_decode_t rd_dec;

   // ************************************************************
   // Handshakes
   // ************************************************************
   // Address and data are each held off while a write response is pending or once taken until the other arrives,
   // so the master may offer them in either order.
   assign s_axi_awready = !state.aw_got && !state.bvalid;
   assign s_axi_wready  = !state.w_got && !state.bvalid;
   assign s_axi_arready = !state.rvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign ar_take       = s_axi_arvalid && s_axi_arready;
   assign rd_dec        = psr_decode(s_axi_araddr);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_state = state;
      wr_dec     = '0;
      if (!aresetn) begin
         next_state             = '0;
         // The bank is refilled from the factory row on every reset cycle.
         next_state.bank        = factory_row;
         next_state.trim.load   = 1'b1;
         next_state.trim.trim_b = factory_row[psr_pkg::SLOT_CAL_B];
         next_state.trim.trim_a = factory_row[psr_pkg::SLOT_CAL_A];
      end else begin
         // Trim values stay driven after reset so the loop keeps its setting.
         next_state.trim.load = 1'b0;
         if (aw_take) begin
            next_state.aw_got = 1'b1;
            next_state.awaddr = s_axi_awaddr;
         end
         if (w_take) begin
            next_state.w_got = 1'b1;
         end
         if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
         end
         if (next_state.aw_got && next_state.w_got && !state.bvalid) begin
            // Write data is dropped: the bank never changes after reset.
            wr_dec            = psr_decode(next_state.awaddr);
            next_state.aw_got = 1'b0;
            next_state.w_got  = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp  = wr_dec.hit ? psr_pkg::RESP_OKAY : psr_pkg::RESP_DECERR;
         end
         if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
         end
         if (ar_take) begin
            next_state.rvalid = 1'b1;
            if (rd_dec.hit) begin
               // Slot order places lot, wafer and coordinate bytes at their own
               // indices, and the 48MHz trim is only ever offered to software.
               next_state.rdata = {24'h000000, state.bank[rd_dec.slot]};
               next_state.rresp = psr_pkg::RESP_OKAY;
            end else begin
               next_state.rdata = 32'h00000000;
               next_state.rresp = psr_pkg::RESP_DECERR;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      state <= next_state;
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // The USB and converter trims leave this block only through AXI reads.
   assign fll_trim     = state.trim;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp  = state.bresp;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rresp  = state.rresp;
   assign s_axi_rdata  = state.rdata;

endmodule

// File: logic/psr_pkg.sv
// Constants, register map and carrier types of the production signature bank.
package psr_pkg;

   // ************************************************************
   // Bus geometry
   // ************************************************************
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int NUM_BYTES = 18;
   localparam int SLOT_W    = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ************************************************************
   // Register indices; the byte address is four times the index
   // ************************************************************
   localparam logic [5:0] IDX_OSC32M_CAL_B_VALUE = 6'h03;
   localparam logic [5:0] IDX_OSC32M_CAL_A_VALUE = 6'h04;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE0   = 6'h08;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE1   = 6'h09;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE2   = 6'h0A;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE3   = 6'h0B;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE4   = 6'h0C;
   localparam logic [5:0] IDX_LOT_NUMBER_BYTE5   = 6'h0D;
   localparam logic [5:0] IDX_WAFER_NUMBER       = 6'h10;
   localparam logic [5:0] IDX_DIE_X_COORD_LOW    = 6'h12;
   localparam logic [5:0] IDX_DIE_X_COORD_HIGH   = 6'h13;
   localparam logic [5:0] IDX_DIE_Y_COORD_LOW    = 6'h14;
   localparam logic [5:0] IDX_DIE_Y_COORD_HIGH   = 6'h15;
   localparam logic [5:0] IDX_USB_PAD_TRIM_LOW   = 6'h1A;
   localparam logic [5:0] IDX_USB_PAD_TRIM_HIGH  = 6'h1B;
   localparam logic [5:0] IDX_OSC_48MHZ_TRIM     = 6'h1C;
   localparam logic [5:0] IDX_ADC_A_TRIM_LOW     = 6'h20;
   localparam logic [5:0] IDX_ADC_A_TRIM_HIGH    = 6'h21;

   // Storage slot k holds the register whose index is SLOT_INDEX[k].
   localparam logic [5:0] SLOT_INDEX [NUM_BYTES] = '{
      IDX_OSC32M_CAL_B_VALUE, IDX_OSC32M_CAL_A_VALUE,
      IDX_LOT_NUMBER_BYTE0,   IDX_LOT_NUMBER_BYTE1,
      IDX_LOT_NUMBER_BYTE2,   IDX_LOT_NUMBER_BYTE3,
      IDX_LOT_NUMBER_BYTE4,   IDX_LOT_NUMBER_BYTE5,
      IDX_WAFER_NUMBER,
      IDX_DIE_X_COORD_LOW,    IDX_DIE_X_COORD_HIGH,
      IDX_DIE_Y_COORD_LOW,    IDX_DIE_Y_COORD_HIGH,
      IDX_USB_PAD_TRIM_LOW,   IDX_USB_PAD_TRIM_HIGH,
      IDX_OSC_48MHZ_TRIM,
      IDX_ADC_A_TRIM_LOW,     IDX_ADC_A_TRIM_HIGH
   };

   localparam logic [SLOT_W-1:0] SLOT_CAL_B = 5'h00;
   localparam logic [SLOT_W-1:0] SLOT_CAL_A = 5'h01;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef logic [NUM_BYTES-1:0][7:0] psr_row_t;

   typedef struct packed {
      logic       load;
      logic [7:0] trim_a;
      logic [7:0] trim_b;
   } psr_fll_trim_t;

   typedef struct packed {
      logic              hit;
      logic [SLOT_W-1:0] slot;
   } psr_decode_t;

endpackage

// File: tb/production_signature_row_tb_top.sv
// Self-checking bench for the signature bank.
`timescale 1ns/10ps
module production_signature_row_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   psr_pkg::psr_row_t row;
   psr_pkg::psr_fll_trim_t trim;
   int n_mismatch = 0, total_checks = 0;
   always #5 aclk = ~aclk;
   psr_bank i_dut (.aclk(aclk), .aresetn(aresetn), .factory_row(row), .fll_trim(trim),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(32'hFFFFFFFF), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   function automatic psr_pkg::psr_row_t pat(input logic [7:0] m);
      for (int k = 0; k < psr_pkg::NUM_BYTES; k++) pat[k] = 8'(k * 29 + 7) ^ m;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Both answer channels are stalled one cycle to show the answer stands.
   task automatic wr(input logic [7:0] a, input logic [1:0] er);
      logic at, wt;
      at = 0;
      wt = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1;
      wvalid <= 1;
      while (!(at && wt)) begin
         @(negedge aclk);
         at = at | awready;
         wt = wt | wready;
         @(posedge aclk);
         if (at) awvalid <= 0;
         if (wt) wvalid <= 0;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      @(posedge aclk);
      bready <= 1;
      @(negedge aclk);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge aclk);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      @(posedge aclk);
      rready <= 1;
      @(negedge aclk);
      chk("rdata", {24'h0, ed}, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      rready <= 0;
   endtask
   task automatic trims(input logic ld);
      @(negedge aclk);
      chk("load", {31'h0, ld}, {31'h0, trim.load});
      chk("trim_b", {24'h0, row[0]}, {24'h0, trim.trim_b});
      chk("trim_a", {24'h0, row[1]}, {24'h0, trim.trim_a});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      row = pat(8'h00);
      repeat (8) @(posedge aclk);
      trims(1'b1);
      @(posedge aclk);
      aresetn <= 1;
      for (int k = 0; k < psr_pkg::NUM_BYTES; k++) begin
         wr({psr_pkg::SLOT_INDEX[k], 2'b00}, psr_pkg::RESP_OKAY);
         rd({psr_pkg::SLOT_INDEX[k], 2'b00}, row[k], psr_pkg::RESP_OKAY);
      end
      trims(1'b0);
      rd({psr_pkg::IDX_USB_PAD_TRIM_LOW, 2'b00}, row[13], psr_pkg::RESP_OKAY);
      rd({psr_pkg::IDX_USB_PAD_TRIM_HIGH, 2'b00}, row[14], psr_pkg::RESP_OKAY);
      rd({psr_pkg::IDX_OSC_48MHZ_TRIM, 2'b00}, row[15], psr_pkg::RESP_OKAY);
      rd({psr_pkg::IDX_ADC_A_TRIM_LOW, 2'b00}, row[16], psr_pkg::RESP_OKAY);
      rd({psr_pkg::IDX_ADC_A_TRIM_HIGH, 2'b00}, row[17], psr_pkg::RESP_OKAY);
      wr(8'h00, psr_pkg::RESP_DECERR);
      rd(8'h38, 8'h00, psr_pkg::RESP_DECERR);
      // A second reset with new factory bytes shows the copy is made every time.
      @(posedge aclk);
      aresetn <= 0;
      row <= pat(8'hFF);
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      // The edge that releases reset still sees it low, so the load bit stands one more cycle.
      trims(1'b1);
      @(posedge aclk);
      trims(1'b0);
      rd({psr_pkg::IDX_WAFER_NUMBER, 2'b00}, row[8], psr_pkg::RESP_OKAY);
      give_verdict();
   end
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule

// File: tb/psr_bank_assertions.sv
// Concurrent checks on the ports of the signature bank.
`timescale 1ns/10ps
module psr_bank_chk (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire psr_pkg::psr_row_t      factory_row,
   input wire psr_pkg::psr_fll_trim_t fll_trim,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire logic [31:0]            s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // The copy checks must run during reset, so they switch the disable off.
   a_trim_load_set: assert property (disable iff (1'b0) !aresetn |=> fll_trim.load)
      else $error("trim load not raised after a reset edge");
   a_trim_b_copy: assert property (disable iff (1'b0)
      !aresetn |=> fll_trim.trim_b == $past(factory_row[0])) else $error("trim b not copied");
   a_trim_a_copy: assert property (disable iff (1'b0)
      !aresetn |=> fll_trim.trim_a == $past(factory_row[1])) else $error("trim a not copied");
   a_trim_load_drop: assert property (aresetn |=> !fll_trim.load)
      else $error("trim load stays high outside reset");
   // The load bit falls on the first edge out of reset, so only the trims are held.
   a_trim_kept: assert property (aresetn |=> $stable({fll_trim.trim_a, fll_trim.trim_b}))
      else $error("trims change outside reset");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   c_read: cover property (s_axi_rvalid && !s_axi_rready);
   c_write: cover property (s_axi_bvalid && !s_axi_bready);
   c_load: cover property (fll_trim.load);
endmodule
bind psr_bank psr_bank_chk i_chk (.aclk(aclk), .aresetn(aresetn), .factory_row(factory_row),
   .fll_trim(fll_trim), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
